// ===== core/timer_status_map.svh
`ifndef TIMER_STATUS_MAP_SVH
`define TIMER_STATUS_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EVENT_STATUS_OFS   8'h0C

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define OSC_HALTED_BIT     7
`define UPDATE_BUSY_BIT    6
`define PERIODIC_BIT       1
`define ALARM_MATCH_BIT    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OSC_HALTED_RST     1'b1
`define PERIODIC_RST       1'b0
`define ALARM_MATCH_RST    1'b0
`define RDATA_RST          8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ             10000000
`define BASE_HZ            4096
`define UPDATE_GUARD_US    60
`define PRESC_BITS         33

`endif

// ===== core/timer_status_pkg.sv
package timer_status_pkg;

  // Bus byte
  typedef logic [7:0] bus_byte_t;
  // Periodic rate select code
  typedef logic [3:0] rate_code_t;
  // Base time counter
  typedef logic [11:0] base_count_t;

endpackage

// ===== core/periodic_tick_gen.sv
`timescale 1ns/1ns
`include "timer_status_map.svh"

module periodic_tick_gen #(
  parameter int PRESC_W = `PRESC_BITS
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     resetn_i,
  // Time base
  input  wire logic                     base_tick_i,
  input  wire timer_status_pkg::rate_code_t rate_code_i,
  // Periodic event
  output logic                          tick_o
);
  import timer_status_pkg::*;

  logic [PRESC_W-1:0] presc_q;     // Base tick prescaler
  logic [PRESC_W-1:0] presc_d;     // Next prescaler value
  logic [5:0]         shift_w;     // Period exponent in base ticks
  logic [PRESC_W-1:0] mask_w;      // Low bits that must all be set

  // ----------------------------------------------------------------
  // Rate code to period exponent
  // ----------------------------------------------------------------
  // Code to exponent
  always_comb begin
    case (rate_code_i)
      4'h1:    shift_w = 6'd0;
      4'h2:    shift_w = 6'd1;
      4'h3:    shift_w = 6'd2;
      4'h4:    shift_w = 6'd3;
      4'h5:    shift_w = 6'd4;
      4'h6:    shift_w = 6'd5;
      4'h7:    shift_w = 6'd9;
      4'h8:    shift_w = 6'd10;
      4'h9:    shift_w = 6'd11;
      4'hA:    shift_w = 6'd12;
      4'hB:    shift_w = 6'd18;
      4'hC:    shift_w = 6'd24;
      4'hD:    shift_w = 6'd28;
      4'hE:    shift_w = 6'd31;
      4'hF:    shift_w = 6'd33;
      default: shift_w = 6'd0;
    endcase
  end

  assign mask_w  = {PRESC_W{1'b1}} >> (6'(PRESC_W) - shift_w);
  assign presc_d = presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
  assign tick_o  = base_tick_i && (rate_code_i != 4'h0) &&
                   ((presc_q & mask_w) == mask_w);

  // Prescaler advances once per base tick
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presc_q <= '0;
    end else if (base_tick_i) begin
      presc_q <= presc_d;
    end
  end

endmodule

// ===== core/timer_status_flags_irq.sv
`timescale 1ns/1ns
`include "timer_status_map.svh"

// What this block does
// - Oscillator halt sets sticky flag bit 7
// - Power-up, dead supplies, battery disable set it
// - Any status write clears set flags
// - Bit 6 high while transfer may happen
// - Busy read low gives 60us write window
// - Busy read low gives 60us read window
// - Transfer fires on busy falling edge
// - Periodic flag bit 1 at selected rate
// - Tick on set periodic flag is dropped
// - Periodic enable pulls interrupt low on flag
// - Alarm match sets flag bit 0
// - Alarm enable pulls interrupt low on flag
// - Rate code zero disables periodic flag
// - Disabled flags leave interrupt alone
module timer_status_flags_irq (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  // Register access strobes
  input  wire timer_status_pkg::bus_byte_t reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire timer_status_pkg::bus_byte_t reg_wdata_i,
  output timer_status_pkg::bus_byte_t      reg_rdata_o,
  // Control bits from control registers
  input  wire logic                        osc_enable_i,
  input  wire logic                        periodic_irq_enable_i,
  input  wire logic                        alarm_irq_enable_i,
  input  wire timer_status_pkg::rate_code_t periodic_rate_code_i,
  // Oscillator and power state
  input  wire logic                        osc_running_i,
  input  wire logic                        on_battery_i,
  // Alarm comparator
  input  wire logic                        alarm_match_i,
  // Outputs
  output logic                             irq_n_o,
  output logic                             update_busy_flag_o,
  output logic                             update_pulse_o
);
  import timer_status_pkg::*;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int          BASE_DIV_INT = `CLK_HZ / `BASE_HZ;
  localparam int          GUARD_INT    =
    (`UPDATE_GUARD_US * (`CLK_HZ / 1000000) + 0);
  localparam base_count_t BASE_LAST    = base_count_t'(BASE_DIV_INT - 1);
  localparam base_count_t BUSY_START   =
    base_count_t'(BASE_DIV_INT - GUARD_INT);
  localparam int          GUARD_CYC    = GUARD_INT;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        osc_meta_q;            // Sync stage one
  logic        osc_run_q;             // Sync stage two
  base_count_t base_cnt_q;            // Base period counter
  base_count_t base_cnt_d;            // Next counter value
  logic        run_w;                 // Time base running
  logic        base_wrap_w;           // End of base period
  logic        busy_q;                // Update busy flag
  logic        busy_d;                // Next busy flag
  logic        update_q;              // Transfer strobe
  logic        osc_halted_q;          // Oscillator halted flag
  logic        osc_halted_d;          // Next halted flag
  logic        periodic_q;            // Periodic flag
  logic        periodic_d;            // Next periodic flag
  logic        alarm_q;               // Alarm flag
  logic        alarm_d;               // Next alarm flag
  logic        irq_n_q;               // Interrupt request, low active
  bus_byte_t   rdata_q;               // Read data holding
  logic        status_sel_w;          // Status address decode
  logic        status_wr_w;           // Status write strobe
  logic        status_rd_w;           // Status read strobe
  logic        halt_cond_w;           // Oscillator halt condition
  logic        periodic_tick_w;       // Periodic event
  logic        irq_req_w;             // Enabled flag pending
  bus_byte_t   status_w;              // Status byte view
  logic [11:0] busy_len_q;            // Busy high length, checking only

  // ----------------------------------------------------------------
  // Oscillator sense synchroniser
  // ----------------------------------------------------------------
  // Two stage sync
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_meta_q <= 1'b0;
      osc_run_q  <= 1'b0;
    end else begin
      osc_meta_q <= osc_running_i;
      osc_run_q  <= osc_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Base time and update busy window
  // ----------------------------------------------------------------
  assign run_w       = osc_enable_i && osc_run_q;
  assign base_wrap_w = run_w && (base_cnt_q == BASE_LAST);
  assign base_cnt_d  = !run_w      ? base_cnt_q :
                       base_wrap_w ? '0 :
                       base_cnt_q + 12'h001;
  assign busy_d      = (base_cnt_d >= BUSY_START);

  // Base counter and busy flag
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_cnt_q <= '0;
      busy_q     <= 1'b0;
      update_q   <= 1'b0;
    end else begin
      base_cnt_q <= base_cnt_d;
      busy_q     <= busy_d;
      update_q   <= busy_q && !busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Periodic rate generator
  // ----------------------------------------------------------------
  // Periodic tick at selected rate
  periodic_tick_gen #(
    .PRESC_W (`PRESC_BITS)
  ) u_tick (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .base_tick_i (base_wrap_w),
    .rate_code_i (periodic_rate_code_i),
    .tick_o      (periodic_tick_w)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign status_sel_w = (reg_addr_i == `EVENT_STATUS_OFS);
  assign status_wr_w  = reg_wr_i && status_sel_w;
  assign status_rd_w  = reg_rd_i && status_sel_w;

  assign status_w = {osc_halted_q, busy_q, 4'h0, periodic_q, alarm_q};

  // ----------------------------------------------------------------
  // Flag next state, set wins over clear
  // ----------------------------------------------------------------
  // Halt, dead supply or battery disable
  assign halt_cond_w  = !osc_run_q || (on_battery_i && !osc_enable_i);
  assign osc_halted_d = halt_cond_w || (osc_halted_q && !status_wr_w);
  // Extra tick leaves set flag alone
  assign periodic_d   = periodic_tick_w || (periodic_q && !status_wr_w);
  assign alarm_d      = alarm_match_i || (alarm_q && !status_wr_w);
  assign irq_req_w    = (periodic_d && periodic_irq_enable_i) ||
                        (alarm_d && alarm_irq_enable_i);

  // Flag registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_halted_q <= `OSC_HALTED_RST;
      periodic_q   <= `PERIODIC_RST;
      alarm_q      <= `ALARM_MATCH_RST;
    end else begin
      osc_halted_q <= osc_halted_d;
      periodic_q   <= periodic_d;
      alarm_q      <= alarm_d;
    end
  end

  // Interrupt output register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_n_q <= 1'b1;
    end else begin
      // Low while any enabled flag set
      irq_n_q <= !irq_req_w;
    end
  end

  // Read data capture, unmapped reads give zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= `RDATA_RST;
    end else if (reg_rd_i) begin
      rdata_q <= status_rd_w ? status_w : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o        = rdata_q;
  assign irq_n_o            = irq_n_q;
  assign update_busy_flag_o = busy_q;
  assign update_pulse_o     = update_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Busy high run length
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_q ? busy_len_q + 12'h001 : 12'h000;
    end
  end

  property p_halt_sets;
    @(posedge clock_i) disable iff (!resetn_i)
    halt_cond_w |=> osc_halted_q;
  endproperty
  a_halt_sets: assert property (p_halt_sets)
    else $error("halted flag not set");

  property p_write_clears;
    @(posedge clock_i) disable iff (!resetn_i)
    (status_wr_w && !periodic_tick_w && !alarm_match_i && !halt_cond_w)
      |=> !periodic_q && !alarm_q && !osc_halted_q;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("status write did not clear flags");

  property p_guard;
    @(posedge clock_i) disable iff (!resetn_i)
    (busy_len_q != 12'h000) && !busy_q |-> busy_len_q == 12'(GUARD_CYC);
  endproperty
  a_guard: assert property (p_guard)
    else $error("busy window shorter than guard");

  property p_update_edge;
    @(posedge clock_i) disable iff (!resetn_i)
    $fell(busy_q) |-> update_pulse_o ##1 !update_pulse_o;
  endproperty
  a_update_edge: assert property (p_update_edge)
    else $error("transfer not on busy fall");

  property p_periodic_set;
    @(posedge clock_i) disable iff (!resetn_i)
    periodic_tick_w |=> periodic_q;
  endproperty
  a_periodic_set: assert property (p_periodic_set)
    else $error("periodic tick lost");

  property p_irq_pf;
    @(posedge clock_i) disable iff (!resetn_i)
    $rose(periodic_q) && $past(periodic_irq_enable_i) |-> !irq_n_o;
  endproperty
  a_irq_pf: assert property (p_irq_pf)
    else $error("periodic interrupt missing");

  property p_alarm_set;
    @(posedge clock_i) disable iff (!resetn_i)
    alarm_match_i |=> alarm_q && status_w[`ALARM_MATCH_BIT];
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm flag not set");

  property p_irq_alarm;
    @(posedge clock_i) disable iff (!resetn_i)
    $rose(alarm_q) && $past(alarm_irq_enable_i) |-> !irq_n_o;
  endproperty
  a_irq_alarm: assert property (p_irq_alarm)
    else $error("alarm interrupt missing");

  property p_irq_cause;
    @(posedge clock_i) disable iff (!resetn_i)
    !irq_n_o |-> (periodic_q && $past(periodic_irq_enable_i)) ||
                 (alarm_q && $past(alarm_irq_enable_i));
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without enabled flag");

  property p_zero_bits;
    @(posedge clock_i) disable iff (!resetn_i)
    reg_rdata_o[5:2] == 4'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("reserved status bits nonzero");

  property p_code_zero;
    @(posedge clock_i) disable iff (!resetn_i)
    (periodic_rate_code_i == 4'h0) |-> !periodic_tick_w;
  endproperty
  a_code_zero: assert property (p_code_zero)
    else $error("periodic tick with code zero");

endmodule

// ===== tb/host_bus.sv
`timescale 1ns/1ns
`include "timer_status_map.svh"

module host_bus (
  // Clock
  input  wire logic                        clock_i,
  // Strobes toward the device
  output timer_status_pkg::bus_byte_t      addr_o,
  output logic                             wr_o,
  output logic                             rd_o,
  output timer_status_pkg::bus_byte_t      wdata_o,
  // Read data back
  input  wire timer_status_pkg::bus_byte_t rdata_i
);
  import timer_status_pkg::*;

  // ----------------------------------------------------------------
  // Idle bus state
  // ----------------------------------------------------------------
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // One strobe cycle, write when w is high, else read
  // ----------------------------------------------------------------
  // status register and unmapped 8'h0B
  // Time registers are never touched, so no collision hazard
  task automatic access(input logic w, input bus_byte_t a, d,
                        output bus_byte_t q);
    @(posedge clock_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines show the inverse, not the stale value
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
  endtask
endmodule

// ===== tb/timer_status_flags_irq_test.sv
`timescale 1ns/1ns
`include "timer_status_map.svh"

module timer_status_flags_irq_test;
  import timer_status_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clock_i, resetn_i, reg_wr_i, reg_rd_i;
  bus_byte_t  reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v, seed;
  logic       osc_enable_i, periodic_irq_enable_i, alarm_irq_enable_i;
  logic       osc_running_i, on_battery_i, alarm_match_i;
  rate_code_t periodic_rate_code_i;
  logic       irq_n_o, update_busy_flag_o, update_pulse_o;
  int         fail_count, cmp_count, cycles, n, p;
  // Clocks per base tick and per update guard span
  localparam int PERIOD_CYC = `CLK_HZ / `BASE_HZ;
  localparam int GUARD_CYC  = `UPDATE_GUARD_US * (`CLK_HZ / 1000000);

  timer_status_flags_irq u_timer_status_flags_irq (
    .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .osc_enable_i(osc_enable_i),
    .periodic_irq_enable_i(periodic_irq_enable_i),
    .alarm_irq_enable_i(alarm_irq_enable_i),
    .periodic_rate_code_i(periodic_rate_code_i),
    .osc_running_i(osc_running_i), .on_battery_i(on_battery_i),
    .alarm_match_i(alarm_match_i), .irq_n_o(irq_n_o),
    .update_busy_flag_o(update_busy_flag_o),
    .update_pulse_o(update_pulse_o));

  host_bus u_host_bus (
    .clock_i(clock_i), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o));

  // ----------------------------------------------------------------
  // Clock and cycle ceiling
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      $display("unexpected at %0t: run too long", $time);
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic bus_byte_t lfsr(input bus_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Periodic flag spacing in clocks, codes 1..6
  function automatic int exp_period(input int code);
    return PERIOD_CYC << (code - 1);
  endfunction

  task automatic conclude();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got,
               exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  // Status read with the busy bit masked off
  task automatic rd_chk(input bus_byte_t exp, input string m);
    u_host_bus.access(1'b0, `EVENT_STATUS_OFS, 8'h00, rd_v);
    chk(rd_v & 8'hBF, exp, m);
  endtask

  task automatic clear(input bus_byte_t d);
    u_host_bus.access(1'b1, `EVENT_STATUS_OFS, d, rd_v);
  endtask

  // Bounded wait for a level on busy or interrupt, counts cycles
  task automatic wait_for(input logic on_busy, input logic v,
                          input int lim, output int c);
    c = 0;
    while ((on_busy ? update_busy_flag_o : irq_n_o) !== v && c < lim) begin
      tick(1);
      c++;
    end
    if (c >= lim)
      chk(0, 1, "wait ran out");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {fail_count, cmp_count, cycles} = '0;
    seed = 8'h09;
    resetn_i = 1'b0;
    {osc_enable_i, osc_running_i} = 2'b11;
    {periodic_irq_enable_i, alarm_irq_enable_i} = 2'b00;
    {on_battery_i, alarm_match_i} = 2'b00;
    periodic_rate_code_i = 4'h0;
    tick(4);
    resetn_i = 1'b1;
    tick(4);
    rd_chk(8'h80, "power-up status");
    chk(irq_n_o, 1'b1, "irq after reset");
    clear(8'hFF);
    rd_chk(8'h00, "halt cleared");
    // Oscillator stop, then restart
    osc_running_i = 1'b0;
    tick(4);
    osc_running_i = 1'b1;
    tick(4);
    rd_chk(8'h80, "halt sticky");
    clear(8'h00);
    // Oscillator disabled on backup supply
    {on_battery_i, osc_enable_i} = 2'b10;
    tick(2);
    {on_battery_i, osc_enable_i} = 2'b01;
    tick(4);
    rd_chk(8'h80, "battery disable");
    u_host_bus.access(1'b1, 8'h0B, 8'hFF, rd_v);
    rd_chk(8'h80, "other write kept");
    u_host_bus.access(1'b0, 8'h0B, 8'h00, rd_v);
    chk(rd_v, 8'h00, "unmapped read");
    clear(8'h5A);
    $display("done: halt flag");
    // Alarm with and without enable
    alarm_match_i = 1'b1;
    tick(1);
    alarm_match_i = 1'b0;
    tick(1);
    chk(irq_n_o, 1'b1, "alarm disabled");
    rd_chk(8'h01, "alarm flag");
    alarm_irq_enable_i = 1'b1;
    tick(1);
    chk(irq_n_o, 1'b0, "alarm enabled");
    alarm_irq_enable_i = 1'b0;
    tick(1);
    chk(irq_n_o, 1'b1, "enable removed");
    alarm_irq_enable_i = 1'b1;
    clear(8'h00);
    chk(irq_n_o, 1'b1, "write releases");
    alarm_match_i = 1'b1;
    tick(1);
    alarm_match_i = 1'b0;
    chk(irq_n_o, 1'b0, "alarm next cycle");
    clear(8'h00);
    // Random enables and alarm pulses
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      alarm_irq_enable_i = seed[0];
      alarm_match_i = seed[1];
      tick(1);
      alarm_match_i = 1'b0;
      tick(1);
      chk(irq_n_o, !(seed[0] & seed[1]), "random irq");
      rd_chk({7'h00, seed[1]}, "random alarm");
      clear(seed);
    end
    alarm_irq_enable_i = 1'b0;
    $display("done: alarm");
    // Rate code zero never sets the periodic flag
    periodic_irq_enable_i = 1'b1;
    tick(2600);
    chk(irq_n_o, 1'b1, "code zero irq");
    rd_chk(8'h00, "code zero flag");
    for (int c = 1; c < 4; c++) begin
      periodic_rate_code_i = c[3:0];
      p = exp_period(c);
      clear(8'h00);
      wait_for(1'b0, 1'b0, p + 10, n);
      clear(8'h00);
      chk(irq_n_o, 1'b1, "periodic cleared");
      wait_for(1'b0, 1'b0, p + 10, n);
      chk(n, p - 2, "periodic spacing");
      rd_chk(8'h02, "periodic flag");
    end
    // Extra ticks on a set flag are dropped
    tick(exp_period(3) + 10);
    clear(8'h00);
    rd_chk(8'h00, "no queued tick");
    chk(irq_n_o, 1'b1, "irq after drop");
    periodic_irq_enable_i = 1'b0;
    $display("done: periodic");
    // Update busy window and transfer strobe
    wait_for(1'b1, 1'b1, 2600, n);
    wait_for(1'b1, 1'b0, 700, n);
    chk(n, GUARD_CYC, "busy length");
    chk(update_pulse_o, 1'b1, "pulse at fall");
    tick(1);
    chk(update_pulse_o, 1'b0, "pulse one cycle");
    u_host_bus.access(1'b0, `EVENT_STATUS_OFS, 8'h00, rd_v);
    chk(rd_v[`UPDATE_BUSY_BIT], 1'b0, "busy reads low");
    wait_for(1'b1, 1'b1, 2600, n);
    chk(n >= GUARD_CYC, 1'b1, "quiet window");
    u_host_bus.access(1'b0, `EVENT_STATUS_OFS, 8'h00, rd_v);
    chk(rd_v[`UPDATE_BUSY_BIT], 1'b1, "busy reads high");
    $display("done: update timing");
    conclude();
  end
endmodule
